// ### nvsc_host.sv
// host controller driving the nv sram pins for reads, writes and stores
`timescale 1ns/1ps
// Contract
// - address stays stable until select and strobe both return high.
// - output gate is held high for the whole write cycle.
// - host may request a store by pulling the busy line low.
// - host samples the busy line before any array access.
// - six reads 0000,1555,0AAA,1FFF,10F0,0F0F start a store.
// - same prefix then 0F0E starts a recall of the shadow.
module nvsc_host #(
	parameter int STORE_CYCLES = nvsc_pkg::STORE_CYC,
	parameter int RECALL_CYCLES = nvsc_pkg::RECALL_CYC,
	parameter int DELAY_CYCLES = nvsc_pkg::DELAY_CYC
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic reqValid,
	input wire nvsc_pkg::nvsc_req_type reqData,
	output logic reqReady,
	output logic rspValid,
	output logic [nvsc_pkg::DATA_W-1:0] rspData,
	output logic nvBusy,
	output logic chipSel_n,
	output logic outGate_n,
	output logic writeStb_n,
	output logic [nvsc_pkg::ADDR_W-1:0] address_lines,
	output logic [nvsc_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe,
	input wire logic [nvsc_pkg::DATA_W-1:0] data_lines_i,
	output logic nv_save_busy_n_o,
	output logic nv_save_busy_n_oe,
	input wire logic nv_save_busy_n_i
);
	typedef enum logic [6:0] {
		NVSC_IDLE = 7'h01,
		NVSC_SETUP = 7'h02,
		NVSC_STROBE = 7'h04,
		NVSC_HOLD = 7'h08,
		NVSC_HWREQ = 7'h10,
		NVSC_WAIT = 7'h20,
		NVSC_BUSY = 7'h40
	} nvsc_state_type;

	nvsc_state_type state_ff, nxt_state;
	nvsc_pkg::nvsc_req_type req_ff, nxt_req;
	logic [nvsc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [2:0] seqIdx_ff, nxt_seqIdx;
	logic [nvsc_pkg::DATA_W-1:0] rdData_ff, nxt_rdData;
	logic rspValid_ff, nxt_rspValid;
	logic busyMeta_ff, busySync_ff;
	logic [nvsc_pkg::DATA_W-1:0] dqMeta_ff, dqSync_ff;
	logic [nvsc_pkg::ADDR_W-1:0] seqAddr;
	nvsc_pkg::nvsc_pins_type pins;

	wire busyLow = ~busySync_ff;
	wire isSeq = req_ff.cmd == nvsc_pkg::NVSC_CMD_SWSTORE ||
		req_ff.cmd == nvsc_pkg::NVSC_CMD_SWRECALL;
	wire isWrite = req_ff.cmd == nvsc_pkg::NVSC_CMD_WRITE;
	wire lastSeq = seqIdx_ff == 3'(nvsc_pkg::SEQ_LEN - 1);
	wire canStart = state_ff == NVSC_IDLE && !busyLow;

	function automatic logic [nvsc_pkg::CNT_W-1:0] cyc(input int n);
		cyc = nvsc_pkg::CNT_W'(n);
	endfunction

	nvsc_seq_rom u_rom (
		.clk_sys(clk_sys),
		.idx(nxt_seqIdx),
		.recall(nxt_req.cmd == nvsc_pkg::NVSC_CMD_SWRECALL),
		.addr(seqAddr)
	);

	// two-flop synchronisers on the pins coming back from the device
	always_ff @(posedge clk_sys) begin
		busyMeta_ff <= nv_save_busy_n_i;
		busySync_ff <= busyMeta_ff;
		dqMeta_ff <= data_lines_i;
		dqSync_ff <= dqMeta_ff;
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_req = req_ff;
		nxt_cnt = cnt_ff;
		nxt_seqIdx = seqIdx_ff;
		nxt_rdData = rdData_ff;
		nxt_rspValid = 1'b0;
		case (state_ff)
			NVSC_IDLE: begin
				if (reqValid && canStart) begin
					nxt_req = reqData;
					nxt_seqIdx = 3'h0;
					nxt_cnt = cyc(nvsc_pkg::SETUP_CYC);
					if (reqData.cmd == nvsc_pkg::NVSC_CMD_HWSTORE) begin
						nxt_state = NVSC_HWREQ;
						nxt_cnt = cyc(DELAY_CYCLES);
					end else begin
						nxt_state = NVSC_SETUP;
					end
				end
			end
			NVSC_SETUP: begin
				// abort a write if busy fell before the strobe
				if (busyLow && isWrite) begin
					nxt_state = NVSC_WAIT;
					nxt_cnt = cyc(STORE_CYCLES);
				end else if (cnt_ff <= cyc(1)) begin
					nxt_state = NVSC_STROBE;
					nxt_cnt = cyc(nvsc_pkg::STROBE_CYC);
				end else begin
					nxt_cnt = cnt_ff - cyc(1);
				end
			end
			NVSC_STROBE: begin
				if (cnt_ff <= cyc(1)) begin
					nxt_state = NVSC_HOLD;
					nxt_cnt = cyc(nvsc_pkg::HOLD_CYC);
				end else begin
					nxt_cnt = cnt_ff - cyc(1);
				end
			end
			NVSC_HOLD: begin
				if (cnt_ff <= cyc(1)) begin
					// late enough for the data to clear both sync flops
					if (!isWrite) nxt_rdData = dqSync_ff;
					if (isSeq && !lastSeq) begin
						nxt_seqIdx = seqIdx_ff + 3'h1;
						nxt_state = NVSC_SETUP;
						nxt_cnt = cyc(nvsc_pkg::SETUP_CYC);
					end else if (isSeq) begin
						nxt_state = NVSC_WAIT;
						nxt_cnt = req_ff.cmd == nvsc_pkg::NVSC_CMD_SWRECALL ?
							cyc(RECALL_CYCLES) : cyc(STORE_CYCLES);
					end else begin
						nxt_state = NVSC_IDLE;
						nxt_rspValid = 1'b1;
					end
				end else begin
					nxt_cnt = cnt_ff - cyc(1);
				end
			end
			NVSC_HWREQ: begin
				// hold the busy line low for the request delay
				if (cnt_ff <= cyc(1)) begin
					nxt_state = NVSC_WAIT;
					nxt_cnt = cyc(STORE_CYCLES);
				end else begin
					nxt_cnt = cnt_ff - cyc(1);
				end
			end
			NVSC_WAIT: begin
				// fixed wait; busy line may stay high if store skipped
				if (cnt_ff <= cyc(1)) begin
					nxt_state = NVSC_BUSY;
				end else begin
					nxt_cnt = cnt_ff - cyc(1);
				end
			end
			NVSC_BUSY: begin
				if (!busyLow) begin
					nxt_state = NVSC_IDLE;
					nxt_rspValid = 1'b1;
				end
			end
			default: nxt_state = NVSC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_ff <= NVSC_IDLE;
			req_ff <= '0;
			cnt_ff <= '0;
			seqIdx_ff <= 3'h0;
			rdData_ff <= '0;
			rspValid_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			req_ff <= nxt_req;
			cnt_ff <= nxt_cnt;
			seqIdx_ff <= nxt_seqIdx;
			rdData_ff <= nxt_rdData;
			rspValid_ff <= nxt_rspValid;
		end
	end

	wire inCycle = state_ff == NVSC_SETUP || state_ff == NVSC_STROBE ||
		state_ff == NVSC_HOLD;
	wire strobing = state_ff == NVSC_STROBE;

	// pin image registered so outputs come from flip-flops
	nvsc_pkg::nvsc_pins_type pins_ff;
	always_comb begin
		// select falls a cycle after the address and rises between reads
		pins.chipSel_n = ~strobing;
		pins.outGate_n = ~(inCycle && !isWrite);
		pins.writeStb_n = ~(strobing && isWrite);
		pins.addressLines = isSeq ? seqAddr : req_ff.addr;
		pins.dataOut = req_ff.data;
		pins.dataOe = inCycle && isWrite;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pins_ff <= '{chipSel_n: 1'b1, outGate_n: 1'b1, writeStb_n: 1'b1,
				addressLines: '0, dataOut: '0, dataOe: 1'b0};
		end else begin
			pins_ff <= pins;
		end
	end

	assign chipSel_n = pins_ff.chipSel_n;
	assign outGate_n = pins_ff.outGate_n;
	assign writeStb_n = pins_ff.writeStb_n;
	assign address_lines = pins_ff.addressLines;
	assign data_lines_o = pins_ff.dataOut;
	assign data_lines_oe = pins_ff.dataOe;
	assign nv_save_busy_n_o = 1'b0;
	assign nv_save_busy_n_oe = state_ff == NVSC_HWREQ;
	assign reqReady = canStart;
	assign rspValid = rspValid_ff;
	assign rspData = rdData_ff;
	assign nvBusy = busyLow || state_ff == NVSC_WAIT;
endmodule

// ### nvsc_pkg.sv
// package: pin map, timing and command types for the nv sram host controller
package nvsc_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CLK_NS = 100;
	// bus phase lengths in cycles
	localparam int SETUP_CYC = 1;
	localparam int STROBE_CYC = 3;
	localparam int HOLD_CYC = 1;
	// store cycle 10 ms
	localparam int STORE_MS = 10;
	localparam int STORE_CYC = STORE_MS * 1000000 / CLK_NS;
	localparam int RECALL_US = 20;
	localparam int RECALL_CYC = RECALL_US * 1000 / CLK_NS;
	localparam int DELAY_US = 25;
	localparam int DELAY_CYC = DELAY_US * 1000 / CLK_NS;
	localparam int SEQ_LEN = 6;
	localparam logic [ADDR_W-1:0] SEQ_A0 = 13'h0000;
	localparam logic [ADDR_W-1:0] SEQ_A1 = 13'h1555;
	localparam logic [ADDR_W-1:0] SEQ_A2 = 13'h0AAA;
	localparam logic [ADDR_W-1:0] SEQ_A3 = 13'h1FFF;
	localparam logic [ADDR_W-1:0] SEQ_A4 = 13'h10F0;
	localparam logic [ADDR_W-1:0] SEQ_STORE = 13'h0F0F;
	localparam logic [ADDR_W-1:0] SEQ_RECALL = 13'h0F0E;
	localparam int CNT_W = 24;

	typedef enum logic [2:0] {
		NVSC_CMD_READ = 3'h0,
		NVSC_CMD_WRITE = 3'h1,
		NVSC_CMD_SWSTORE = 3'h2,
		NVSC_CMD_SWRECALL = 3'h3,
		NVSC_CMD_HWSTORE = 3'h4
	} nvsc_cmd_type;

	typedef struct packed {
		nvsc_cmd_type cmd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} nvsc_req_type;

	typedef struct packed {
		logic chipSel_n;
		logic outGate_n;
		logic writeStb_n;
		logic [ADDR_W-1:0] addressLines;
		logic [DATA_W-1:0] dataOut;
		logic dataOe;
	} nvsc_pins_type;
endpackage

// ### nvsc_seq_rom.sv
// small rom holding the six-address software store/recall sequence
`timescale 1ns/1ps
module nvsc_seq_rom (
	input wire logic clk_sys,
	input wire logic [2:0] idx,
	input wire logic recall,
	output logic [nvsc_pkg::ADDR_W-1:0] addr
);
	logic [nvsc_pkg::ADDR_W-1:0] addr_ff;
	logic [nvsc_pkg::ADDR_W-1:0] nxtAddr;

	always_comb begin
		case (idx)
			3'h0: nxtAddr = nvsc_pkg::SEQ_A0;
			3'h1: nxtAddr = nvsc_pkg::SEQ_A1;
			3'h2: nxtAddr = nvsc_pkg::SEQ_A2;
			3'h3: nxtAddr = nvsc_pkg::SEQ_A3;
			3'h4: nxtAddr = nvsc_pkg::SEQ_A4;
			default: nxtAddr = recall ? nvsc_pkg::SEQ_RECALL :
				nvsc_pkg::SEQ_STORE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		addr_ff <= nxtAddr;
	end
	assign addr = addr_ff;
endmodule

// ### nvsc_dev_model.sv
// behavioural nv sram device as seen from the host pins
`timescale 1ns/1ps
module nvsc_dev_model #(
	parameter bit AUTO_INHIBIT = 1'b0,
	parameter int STORE_NS = 2000,
	parameter int RECALL_NS = 1000,
	parameter int DELAY_NS = 400
) (
	input wire logic chipSel_n,
	input wire logic outGate_n,
	input wire logic writeStb_n,
	input wire logic [12:0] address_lines,
	input wire logic [7:0] data_lines,
	input wire logic busyLine,
	output logic [7:0] dqOut,
	output logic dqOe,
	output logic busyPull
);
	logic [7:0] mem [8192];
	logic [7:0] shadow [8192];
	logic [12:0] tbl [5] = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
	logic [12:0] aLat = 13'h0000;
	logic wrOn = 1'b0;
	logic rdOn = 1'b0;
	logic dirty = 1'b0;
	logic nvOp = 1'b0;
	logic supplyLow = 1'b0;
	logic capIsolated = 1'b0;
	int seqPos = 0;
	int stores = 0;
	event doSave;
	event doRecall;
	initial busyPull = 1'b0;
	assign dqOe = !chipSel_n && !outGate_n && writeStb_n && busyLine && !nvOp;
	assign dqOut = mem[address_lines];
	always @(negedge chipSel_n) aLat = address_lines;
	always @(chipSel_n or writeStb_n) begin
		if (!chipSel_n && !writeStb_n && busyLine && !nvOp) begin
			wrOn = 1'b1;
			rdOn = 1'b0;
		end else if (wrOn) begin
			mem[aLat] = data_lines;
			wrOn = 1'b0;
			dirty = 1'b1;
			seqPos = 0;
		end
		if (!chipSel_n && writeStb_n && !nvOp) rdOn = 1'b1;
		else if (rdOn && chipSel_n) begin
			rdOn = 1'b0;
			if (seqPos == 5) begin
				if (aLat == 13'h0F0F) ->doSave;
				if (aLat == 13'h0F0E) ->doRecall;
				seqPos = 0;
			end else if (aLat == tbl[seqPos]) seqPos++;
			else seqPos = int'(aLat == 13'h0000);
		end
	end
	always @(negedge busyLine) begin
		if (!busyPull) begin
			#(DELAY_NS);
			if (dirty) ->doSave;
		end
	end
	// supply drop: hold-up capacitor cut off from supply, one store
	always @(posedge supplyLow) begin
		capIsolated = 1'b1;
		if (!AUTO_INHIBIT && dirty) ->doSave;
	end
	always @(doSave) begin
		nvOp = 1'b1;
		busyPull = 1'b1;
		stores++;
		foreach (mem[i]) shadow[i] = mem[i];
		#(STORE_NS);
		busyPull = 1'b0;
		nvOp = 1'b0;
		dirty = 1'b0;
	end
	always @(doRecall) begin
		nvOp = 1'b1;
		foreach (mem[i]) mem[i] = 8'h00;
		foreach (mem[i]) mem[i] = shadow[i];
		#(RECALL_NS);
		nvOp = 1'b0;
		dirty = 1'b0;
	end
endmodule

// ### nvsc_host_asserts.sv
// pin-level assertions for the host controller
`timescale 1ns/1ps
module nvsc_host_asserts (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic reqValid,
	input wire nvsc_pkg::nvsc_req_type reqData,
	input wire logic reqReady,
	input wire logic rspValid,
	input wire logic nvBusy,
	input wire logic chipSel_n,
	input wire logic outGate_n,
	input wire logic writeStb_n,
	input wire logic [nvsc_pkg::ADDR_W-1:0] address_lines,
	input wire logic data_lines_oe,
	input wire logic nv_save_busy_n_oe,
	input wire logic nv_save_busy_n_i
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence rdTaken;
		reqValid && reqReady && reqData.cmd == nvsc_pkg::NVSC_CMD_READ;
	endsequence
	sequence rdPins;
		!chipSel_n && !outGate_n && writeStb_n && !data_lines_oe;
	endsequence
	read_pins_a: assert property (rdTaken |-> ##3 rdPins
		##0 address_lines == $past(reqData.addr, 3)) else $error("read pins");
	read_answer_a: assert property (rdTaken |-> ##[5:6] rspValid)
		else $error("read answer late");
	addr_stable_a: assert property (!chipSel_n && $past(!chipSel_n)
		|-> $stable(address_lines)) else $error("address moved");
	write_gate_a: assert property (!writeStb_n |-> outGate_n && data_lines_oe)
		else $error("write gate");
	no_contend_a: assert property (data_lines_oe |-> outGate_n)
		else $error("data contention");
	idle_desel_a: assert property (reqReady |-> chipSel_n && writeStb_n)
		else $error("selected while idle");
	busy_blocks_a: assert property ((!nv_save_busy_n_i)[*3]
		|-> !reqReady && nvBusy) else $error("access while busy");
	hw_pull_a: assert property (reqValid && reqReady
		&& reqData.cmd == nvsc_pkg::NVSC_CMD_HWSTORE
		|-> ##[1:3] nv_save_busy_n_oe) else $error("no busy pull");
endmodule

// ### nvsc_host_tb.sv
// testbench: host controller against the device model
`timescale 1ns/1ps
module nvsc_host_tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic reqValid = 1'b0;
	nvsc_pkg::nvsc_req_type reqData = '0;
	logic reqReady, rspValid, nvBusy, chipSel_n, outGate_n, writeStb_n;
	logic [7:0] rspData, dOut, dqOut, dqWire;
	logic [12:0] address_lines;
	logic dOe, dqOe, busyOe, busyPull, busyWire;
	int mismatches = 0;
	int comparisons = 0;
	int waitCnt;
	int s;
	assign busyWire = !(busyOe || busyPull);
	// released data lines toggle so stale values never pass
	assign dqWire = dOe ? dOut : dqOe ? dqOut : {8{clk_sys}};
	nvsc_host #(.STORE_CYCLES(20), .RECALL_CYCLES(10), .DELAY_CYCLES(5)) dut (
		.clk_sys, .reset, .reqValid, .reqData, .reqReady, .rspValid,
		.rspData, .nvBusy, .chipSel_n, .outGate_n, .writeStb_n,
		.address_lines, .data_lines_o(dOut), .data_lines_oe(dOe),
		.data_lines_i(dqWire), .nv_save_busy_n_o(),
		.nv_save_busy_n_oe(busyOe), .nv_save_busy_n_i(busyWire));
	nvsc_dev_model dev (.chipSel_n, .outGate_n, .writeStb_n, .address_lines,
		.data_lines(dqWire), .busyLine(busyWire), .dqOut, .dqOe, .busyPull);
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic step();
		@(posedge clk_sys);
		#1;
		waitCnt++;
		if (waitCnt > 4000) begin
			mismatches++;
			finish_test();
		end
	endtask
	task automatic issue(input nvsc_pkg::nvsc_cmd_type c,
		input logic [12:0] a, input logic [7:0] d);
		waitCnt = 0;
		while (reqReady !== 1'b1) step();
		reqData = '{c, a, d};
		reqValid = 1'b1;
		step();
		reqValid = 1'b0;
		while (rspValid !== 1'b1) step();
	endtask
	task automatic rw_scen();
		issue(nvsc_pkg::NVSC_CMD_WRITE, 13'h1FFF, 8'hA5);
		issue(nvsc_pkg::NVSC_CMD_WRITE, 13'h0000, 8'h5A);
		cmp(dev.mem[13'h1FFF], 8'hA5);
		issue(nvsc_pkg::NVSC_CMD_READ, 13'h1FFF, 8'h00);
		cmp(rspData, 8'hA5);
		issue(nvsc_pkg::NVSC_CMD_READ, 13'h0000, 8'h00);
		cmp(rspData, 8'h5A);
	endtask
	task automatic sw_scen();
		s = dev.stores;
		issue(nvsc_pkg::NVSC_CMD_SWSTORE, 13'h0000, 8'h00);
		cmp(8'(dev.stores - s), 8'h01);
		issue(nvsc_pkg::NVSC_CMD_SWSTORE, 13'h0000, 8'h00);
		cmp(8'(dev.stores - s), 8'h02);
		issue(nvsc_pkg::NVSC_CMD_WRITE, 13'h1FFF, 8'h3C);
		issue(nvsc_pkg::NVSC_CMD_SWRECALL, 13'h0000, 8'h00);
		issue(nvsc_pkg::NVSC_CMD_READ, 13'h1FFF, 8'h00);
		cmp(rspData, 8'hA5);
	endtask
	task automatic hw_scen();
		s = dev.stores;
		issue(nvsc_pkg::NVSC_CMD_HWSTORE, 13'h0000, 8'h00);
		cmp(8'(dev.stores - s), 8'h00);
		issue(nvsc_pkg::NVSC_CMD_WRITE, 13'h0000, 8'h77);
		issue(nvsc_pkg::NVSC_CMD_HWSTORE, 13'h0000, 8'h00);
		cmp(8'(dev.stores - s), 8'h01);
		cmp(dev.shadow[13'h0000], 8'h77);
	endtask
	task automatic pl_scen();
		s = dev.stores;
		issue(nvsc_pkg::NVSC_CMD_WRITE, 13'h0001, 8'h11);
		dev.supplyLow = 1'b1;
		repeat (4) step();
		cmp(8'(nvBusy), 8'h01);
		cmp(8'(reqReady), 8'h00);
		dev.supplyLow = 1'b0;
		waitCnt = 0;
		while (nvBusy !== 1'b0) step();
		cmp(8'(dev.stores - s), 8'h01);
		cmp(dev.shadow[13'h0001], 8'h11);
	endtask
	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		rw_scen();
		sw_scen();
		hw_scen();
		pl_scen();
		finish_test();
	end
endmodule
bind nvsc_host nvsc_host_asserts chk (.clk_sys, .reset, .reqValid, .reqData,
	.reqReady, .rspValid, .nvBusy, .chipSel_n, .outGate_n, .writeStb_n,
	.address_lines, .data_lines_oe, .nv_save_busy_n_oe, .nv_save_busy_n_i);
